// file: design/sff_params.svh
// constants for the serial flash transfer framing block
`ifndef SFF_PARAMS_SVH
`define SFF_PARAMS_SVH
`define SFF_BYTE_BITS   8
`define SFF_LANES       4
`define SFF_LANE_SO     1
`define SFF_LANE_THREE  3
`define SFF_CMD_LANES   3'h1
`define SFF_QUAD_LANES  3'h4
`define SFF_DUAL_LANES  3'h2
`define SFF_ADDR_BYTES  3'h3
`endif

// file: design/sff_pkg.sv
// types shared by the serial flash transfer framing block
package sff_pkg;
	// phase of the transfer currently on the lanes
	typedef enum logic [2:0] {
		SFF_PH_START,
		SFF_PH_CMD,
		SFF_PH_ADDR,
		SFF_PH_DUMMY,
		SFF_PH_DATA,
		SFF_PH_DONE
	} sff_phase_t;

	// x-y-z transfer shape; lane counts of 0 mean the phase is absent
	typedef struct packed {
		logic [2:0] addr_lanes;
		logic [2:0] addr_bytes;
		logic [3:0] dummy_cyc;
		logic [2:0] data_lanes;
		logic       data_rd;
	} sff_fmt_t;

	// one received byte and the phase it arrived in
	typedef struct packed {
		sff_phase_t phase;
		logic [7:0] data;
	} sff_rx_t;
endpackage

// file: design/sff_framing.sv
// serial flash framing: pin roles, x-y-z lane sequencing, pause and pin reset
`timescale 1ns/1ps
`include "sff_params.svh"


// three-stage synchroniser; output follows once stages two and three agree
module sff_sync3 (
	input  wire logic mclk_i,
	input  wire logic resetn_i,
	input  wire logic d_i,
	output logic      q_o
);
	logic [2:0] st_r;

	always_ff @(posedge mclk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			st_r <= 3'h0;
		else
			st_r <= {st_r[1:0], d_i};
	end

	always_ff @(posedge mclk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			q_o <= 1'b0;
		else if (st_r[1] == st_r[2])
			q_o <= st_r[2];
	end
endmodule // sff_sync3

module sff_framing
	import sff_pkg::*;
(
	// system
	input  wire logic          mclk_i,
	input  wire logic          resetn_i,
	// link pins
	input  wire logic          sck_i,
	input  wire logic          cs_n_i,
	input  wire logic [3:0]    io_i,
	output logic      [3:0]    io_o,
	output logic      [3:0]    io_oe_o,
	// configuration
	input  wire logic          four_lane_enable_i,
	input  wire logic          lane_three_reset_i,
	input  wire logic          execute_in_place_mode_i,
	input  wire sff_pkg::sff_fmt_t fmt_i,
	// received bytes
	output logic               rx_valid_o,
	output sff_pkg::sff_rx_t   rx_o,
	// read data
	input  wire logic          tx_valid_i,
	input  wire logic [7:0]    tx_data_i,
	output logic               tx_ready_o,
	// status
	output logic               frame_active_o,
	output logic               hw_reset_o
);
	import sff_pkg::*;

	sff_fmt_t   fmt_r;
	sff_phase_t phase_r;
	sff_phase_t ph_eff;
	sff_phase_t ph_after_addr;
	sff_phase_t ph_after_cmd;
	logic [2:0] lane_w;
	logic [3:0] bit_cnt_r;
	logic [3:0] bit_cnt_nxt;
	logic [2:0] byte_cnt_r;
	logic [3:0] dum_cnt_r;
	logic [7:0] in_sh_r;
	logic [7:0] in_sh_nxt;
	logic [7:0] out_sh_r;
	logic [3:0] out_oe_r;
	logic       rx_tgl_r;
	sff_rx_t    rx_word_r;
	logic       tx_tgl_r;
	logic [7:0] tx_hold_r;
	logic       tx_full_r;
	logic       frame_rst_n;
	logic       pause_w;
	logic       quad_ok;
	logic       cs_n_s;
	logic       lane3_s;
	logic       rx_tgl_s;
	logic       rx_seen_r;
	logic       tx_tgl_s;
	logic       tx_seen_r;

	// ------------------------------------------------------------
	// pin roles
	// ------------------------------------------------------------
	assign quad_ok     = four_lane_enable_i;
	assign pause_w     = ~four_lane_enable_i & ~lane_three_reset_i & ~io_i[`SFF_LANE_THREE] & ~cs_n_i;
	assign frame_rst_n = resetn_i & ~cs_n_i;

	sff_sync3 u_cs_sync    (.mclk_i(mclk_i), .resetn_i(resetn_i), .d_i(~cs_n_i), .q_o(cs_n_s));
	sff_sync3 u_lane3_sync (.mclk_i(mclk_i), .resetn_i(resetn_i), .d_i(~io_i[`SFF_LANE_THREE]), .q_o(lane3_s));
	sff_sync3 u_rx_sync    (.mclk_i(mclk_i), .resetn_i(resetn_i), .d_i(rx_tgl_r), .q_o(rx_tgl_s));
	sff_sync3 u_tx_sync    (.mclk_i(mclk_i), .resetn_i(resetn_i), .d_i(tx_tgl_r), .q_o(tx_tgl_s));

	// ------------------------------------------------------------
	// phase sequencing on the link clock
	// ------------------------------------------------------------
	always_comb
	begin
		ph_after_addr = (fmt_r.dummy_cyc != 4'h0) ? SFF_PH_DUMMY :
		                (fmt_r.data_lanes != 3'h0) ? SFF_PH_DATA : SFF_PH_DONE;
		ph_after_cmd  = (fmt_r.addr_lanes != 3'h0) ? SFF_PH_ADDR : ph_after_addr;
		ph_eff        = phase_r;
		if (phase_r == SFF_PH_START)
			ph_eff = (execute_in_place_mode_i && quad_ok) ? SFF_PH_ADDR : SFF_PH_CMD;
	end

	always_comb
	begin
		case (ph_eff)
			SFF_PH_ADDR: lane_w = fmt_r.addr_lanes;
			SFF_PH_DATA: lane_w = fmt_r.data_lanes;
			default:     lane_w = `SFF_CMD_LANES;
		endcase
		if (ph_eff == SFF_PH_ADDR && execute_in_place_mode_i && phase_r == SFF_PH_START)
			lane_w = `SFF_QUAD_LANES;
		if (lane_w == `SFF_QUAD_LANES && !quad_ok)
			lane_w = `SFF_CMD_LANES;
	end

	// msb first; single lane reads the input lane
	always_comb
	begin
		case (lane_w)
			`SFF_QUAD_LANES: in_sh_nxt = {in_sh_r[3:0], io_i};
			`SFF_DUAL_LANES: in_sh_nxt = {in_sh_r[5:0], io_i[1:0]};
			default:         in_sh_nxt = {in_sh_r[6:0], io_i[0]};
		endcase
		bit_cnt_nxt = bit_cnt_r + {1'b0, lane_w};
	end

	// sampling on the rising edge; either clock idle level works
	always_ff @(posedge sck_i or negedge frame_rst_n)
	begin
		if (!frame_rst_n)
		begin
			phase_r    <= SFF_PH_START;
			bit_cnt_r  <= 4'h0;
			byte_cnt_r <= 3'h0;
			dum_cnt_r  <= 4'h0;
			in_sh_r    <= 8'h00;
		end
		else if (!pause_w)
		begin
			phase_r <= ph_eff;
			case (ph_eff)
				SFF_PH_CMD, SFF_PH_ADDR, SFF_PH_DATA:
				begin
					in_sh_r   <= in_sh_nxt;
					bit_cnt_r <= (bit_cnt_nxt >= 4'h8) ? 4'h0 : bit_cnt_nxt;
					if (bit_cnt_nxt >= 4'h8)
					begin
						if (ph_eff == SFF_PH_CMD)
							phase_r <= ph_after_cmd;
						else if (ph_eff == SFF_PH_ADDR)
						begin
							byte_cnt_r <= byte_cnt_r + 3'h1;
							if (byte_cnt_r == fmt_r.addr_bytes - 3'h1)
								phase_r <= ph_after_addr;
						end
					end
				end
				SFF_PH_DUMMY:
				begin
					dum_cnt_r <= dum_cnt_r + 4'h1;
					if (dum_cnt_r == fmt_r.dummy_cyc - 4'h1)
						phase_r <= (fmt_r.data_lanes != 3'h0) ? SFF_PH_DATA : SFF_PH_DONE;
				end
				default:
				begin
					phase_r <= ph_eff;
				end
			endcase
		end
	end

	// received byte handed over by toggle; not cleared at frame end
	always_ff @(posedge sck_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			rx_tgl_r  <= 1'b0;
			rx_word_r <= '0;
		end
		else if (!cs_n_i && !pause_w && bit_cnt_nxt >= 4'h8 &&
		         (ph_eff == SFF_PH_CMD || ph_eff == SFF_PH_ADDR ||
		          (ph_eff == SFF_PH_DATA && !fmt_r.data_rd)))
		begin
			rx_tgl_r  <= ~rx_tgl_r;
			rx_word_r <= '{phase: ph_eff, data: in_sh_nxt};
		end
	end

	// ------------------------------------------------------------
	// read data launched on the falling edge
	// ------------------------------------------------------------
	always_ff @(negedge sck_i or negedge frame_rst_n)
	begin
		if (!frame_rst_n)
		begin
			out_sh_r <= 8'h00;
			out_oe_r <= 4'h0;
		end
		else if (!pause_w)
		begin
			if (phase_r == SFF_PH_DATA && fmt_r.data_rd)
			begin
				if (bit_cnt_r == 4'h0)
					out_sh_r <= tx_hold_r;
				else
					out_sh_r <= out_sh_r << lane_w;
				case (lane_w)
					`SFF_QUAD_LANES: out_oe_r <= 4'hF;
					`SFF_DUAL_LANES: out_oe_r <= 4'h3;
					default:         out_oe_r <= 4'h2;
				endcase
			end
			else
				out_oe_r <= 4'h0;
		end
	end

	always_ff @(negedge sck_i or negedge resetn_i)
	begin
		if (!resetn_i)
			tx_tgl_r <= 1'b0;
		else if (frame_rst_n && !pause_w && phase_r == SFF_PH_DATA && fmt_r.data_rd && bit_cnt_r == 4'h0)
			tx_tgl_r <= ~tx_tgl_r;
	end

	always_comb
	begin
		case (out_oe_r)
			4'hF:    io_o = out_sh_r[7:4];
			4'h3:    io_o = {2'h0, out_sh_r[7:6]};
			default: io_o = {2'h0, out_sh_r[7], 1'b0};
		endcase
	end

	assign io_oe_o = (cs_n_i || pause_w) ? 4'h0 : out_oe_r;

	// ------------------------------------------------------------
	// system clock side
	// ------------------------------------------------------------
	// shape only changes while deselected, so the link side sees it stable
	always_ff @(posedge mclk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			fmt_r <= '0;
		else if (!cs_n_s && cs_n_i)
			fmt_r <= fmt_i;
	end

	always_ff @(posedge mclk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			hw_reset_o <= 1'b0;
		else
			hw_reset_o <= lane3_s & lane_three_reset_i & ~four_lane_enable_i;
	end

	always_ff @(posedge mclk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			rx_seen_r  <= 1'b0;
			rx_valid_o <= 1'b0;
			rx_o       <= '0;
		end
		else
		begin
			rx_seen_r  <= rx_tgl_s;
			rx_valid_o <= (rx_tgl_s != rx_seen_r) & ~hw_reset_o;
			if (rx_tgl_s != rx_seen_r)
				rx_o <= rx_word_r;
		end
	end

	always_ff @(posedge mclk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			tx_seen_r <= 1'b0;
			tx_full_r <= 1'b0;
			tx_hold_r <= 8'h00;
		end
		else
		begin
			tx_seen_r <= tx_tgl_s;
			if (hw_reset_o)
				tx_full_r <= 1'b0;
			else if (tx_valid_i && !tx_full_r)
			begin
				tx_full_r <= 1'b1;
				tx_hold_r <= tx_data_i;
			end
			else if (tx_tgl_s != tx_seen_r)
				tx_full_r <= 1'b0;
		end
	end

	assign tx_ready_o     = ~tx_full_r;
	assign frame_active_o = cs_n_s;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	sequence s_cmd_last;
		ph_eff == SFF_PH_CMD && bit_cnt_r == 4'h7 && !pause_w;
	endsequence

	a_cmd_only_ends: assert property (@(posedge sck_i) disable iff (!frame_rst_n)
		s_cmd_last ##0 (fmt_r.addr_lanes == 3'h0 && fmt_r.dummy_cyc == 4'h0 && fmt_r.data_lanes == 3'h0)
		|=> phase_r == SFF_PH_DONE) else $error("command-only transfer did not end");
	a_cmd_then_addr: assert property (@(posedge sck_i) disable iff (!frame_rst_n)
		s_cmd_last ##0 (fmt_r.addr_lanes != 3'h0) |=> phase_r == SFF_PH_ADDR)
		else $error("address phase did not follow command");
	a_pause_freezes: assert property (@(posedge mclk_i) disable iff (!frame_rst_n)
		pause_w |=> $stable(bit_cnt_r) && $stable(phase_r)) else $error("pause moved sequencing");
	a_pause_quad_off: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		four_lane_enable_i |-> !pause_w && !hw_reset_o) else $error("lane three used as control in quad");
	a_pause_needs_cs: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		cs_n_i |-> !pause_w) else $error("pause honoured while deselected");
	a_deselect_hiz: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		cs_n_i |-> io_oe_o == 4'h0) else $error("lanes driven while deselected");
	a_cmd_one_lane: assert property (@(posedge sck_i) disable iff (!frame_rst_n)
		ph_eff == SFF_PH_CMD |-> lane_w == `SFF_CMD_LANES) else $error("command not single lane");
	a_xip_no_cmd: assert property (@(posedge sck_i) disable iff (!frame_rst_n)
		phase_r == SFF_PH_START && execute_in_place_mode_i && quad_ok
		|-> ph_eff == SFF_PH_ADDR && lane_w == `SFF_QUAD_LANES) else $error("command sent in xip");
	a_pin_reset: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		lane_three_reset_i && !four_lane_enable_i && !io_i[`SFF_LANE_THREE] [*8]
		|-> hw_reset_o) else $error("pin reset not taken");
endmodule // sff_framing

// file: verification/sff_host_model.sv
// host-side serial controller model driving select, link clock and lanes
`timescale 1ns/1ps
module sff_host_model (
	// link pins
	output logic            sck_o,
	output logic            cs_n_o,
	output logic [3:0]      io_o,
	output logic [3:0]      io_oe_o,
	// resolved lane levels
	input  wire logic [3:0] lane_i
);
	// half period of the 48 ns link clock
	localparam realtime HALF = 24.0;
	logic idle_hi;
	int   hold_at;

	initial
	begin
		{sck_o, cs_n_o, io_o, io_oe_o} = 10'h000;
		idle_hi = 1'b0;
		hold_at = -1;
		// deselect after the bench has asserted reset, so the frame reset sees a clean edge
		#2 cs_n_o = 1'b1;
	end

	// clock only runs inside a frame; idle level picks mode 0 or 3
	task automatic sel(input bit on);
		if (on)
		begin
			#1.3 sck_o = idle_hi;
			#HALF cs_n_o = 1'b0;
		end
		else
		begin
			#HALF sck_o = idle_hi;
			io_oe_o = 4'h0;
			#HALF cs_n_o = 1'b1;
			#(2 * HALF);
		end
	endtask

	task automatic xfer(input logic [7:0] b, input int lanes, input bit rd, output logic [7:0] r);
		logic [7:0] sh;
		sh = b;
		r = 8'h00;
		for (int i = 0; i < 8 / lanes; i++)
		begin
			sck_o = 1'b0;
			if (i == hold_at)
			begin
				io_o[3] = 1'b1;
				io_oe_o[3] = 1'b1;
				#2 io_o[3] = 1'b0;
				#(4 * HALF) io_o[3] = 1'b1;
				#HALF;
			end
			io_oe_o = rd ? 4'h0 : 4'((1 << lanes) - 1);
			io_o = (lanes == 4) ? sh[7:4] : (lanes == 2) ? {2'h0, sh[7:6]} : {3'h0, sh[7]};
			sh = sh << lanes;
			#HALF r = (lanes == 4) ? {r[3:0], lane_i} : (lanes == 2) ? {r[5:0], lane_i[1:0]} : {r[6:0], lane_i[1]};
			sck_o = 1'b1;
			#HALF;
		end
	endtask

	// idle link clocks with the lanes released, for dummy cycles
	task automatic clocks(input int n);
		for (int i = 0; i < n; i++)
		begin
			sck_o = 1'b0;
			io_oe_o = 4'h0;
			#HALF sck_o = 1'b1;
			#HALF;
		end
	endtask

	task automatic pin3(input bit v);
		io_o[3] = v;
		io_oe_o[3] = 1'b1;
	endtask
endmodule // sff_host_model

// file: verification/testbench.sv
// self-checking bench for the serial flash framing block
`timescale 1ns/1ps
module testbench;
	import sff_pkg::*;
	logic       mclk, resetn, sck, cs_n, fle, l3rst, execute_in_place_mode, tx_valid, rx_valid, tx_ready, act, hwrst;
	logic [3:0] dio, doe, hio, hoe, lane, junk;
	logic [7:0] tx_data, r, b;
	sff_fmt_t   fmt;
	sff_rx_t    rx;
	sff_rx_t    exp_q[$];
	int         n_errors, tests_run;
	int         nab, dum;
	// address lanes, data lanes, execute-in-place for each write shape
	int         shp[7][3] = '{'{0,0,0}, '{1,0,0}, '{1,1,0}, '{1,2,0}, '{1,4,0}, '{4,4,0}, '{4,4,1}};
	int         rl[3] = '{1, 2, 4};

	initial
	begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end

	// released lanes two and three are pulled up, the others wander
	always @(posedge mclk) junk <= resetn ? ~junk : 4'h5;
	always_comb
		for (int k = 0; k < 4; k++)
			lane[k] = doe[k] ? dio[k] : hoe[k] ? hio[k] : (k > 1) ? 1'b1 : junk[k];

	sff_framing i_dut (.mclk_i(mclk), .resetn_i(resetn), .sck_i(sck), .cs_n_i(cs_n), .io_i(lane), .io_o(dio),
		.io_oe_o(doe), .four_lane_enable_i(fle), .lane_three_reset_i(l3rst), .execute_in_place_mode_i(execute_in_place_mode),
		.fmt_i(fmt), .rx_valid_o(rx_valid), .rx_o(rx), .tx_valid_i(tx_valid), .tx_data_i(tx_data),
		.tx_ready_o(tx_ready), .frame_active_o(act), .hw_reset_o(hwrst));
	sff_host_model i_host (.sck_o(sck), .cs_n_o(cs_n), .io_o(hio), .io_oe_o(hoe), .lane_i(lane));

	task automatic check(input logic [10:0] got, input logic [10:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			n_errors++;
			$display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask

	task automatic end_of_test();
		if (n_errors == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// watcher: every reported byte against the oldest note
	always @(posedge mclk)
	begin
		if (rx_valid)
			check(rx, (exp_q.size() == 0) ? 11'h7FF : exp_q.pop_front());
		if (cs_n && resetn)
			check({7'h0, doe}, 11'h0);
	end

	task automatic setup(input int a, input int n, input int dc, input int d, input bit rd, input bit x,
		input bit m3);
		@(posedge mclk);
		fle <= (a == 4) || (d == 4);
		l3rst <= ((a == 4) || (d == 4)) ? 1'($urandom) : 1'b0;
		execute_in_place_mode <= x;
		fmt <= '{addr_lanes: 3'(a), addr_bytes: 3'(n), dummy_cyc: 4'(dc),
			data_lanes: 3'(d), data_rd: rd};
		i_host.idle_hi = m3;
		repeat (8) @(posedge mclk);
	endtask

	task automatic send(input sff_phase_t ph, input int lanes);
		logic [7:0] v;
		logic [7:0] dummy;
		v = 8'($urandom);
		exp_q.push_back('{phase: ph, data: v});
		i_host.xfer(v, lanes, 1'b0, dummy);
	endtask

	task automatic offer(input logic [7:0] v);
		@(posedge mclk);
		tx_valid <= 1'b1;
		tx_data <= v;
		for (int w = 0; w < 20; w++)
		begin
			@(posedge mclk);
			if (tx_ready === 1'b1)
				break;
		end
		tx_valid <= 1'b0;
	endtask

	initial
	begin
		resetn = 1'b1;
		#1;
		{resetn, fle, l3rst, execute_in_place_mode, tx_valid, tx_data} = '0;
		fmt = '0;
		n_errors = 0;
		tests_run = 0;
		void'($urandom(21539));
		repeat (8) @(posedge mclk);
		resetn <= 1'b1;
		// write shapes, alternating clock modes, a pause inside every byte of the third shape
		for (int t = 0; t < 7; t++)
		begin
			nab = (shp[t][0] != 0) ? 1 + $urandom % 3 : 0;
			setup(shp[t][0], nab, 0, shp[t][1], 1'b0, shp[t][2] == 1, t % 2 == 1);
			i_host.hold_at = (t == 2) ? 3 : -1;
			i_host.sel(1'b1);
			if (shp[t][2] == 0)
				send(SFF_PH_CMD, 1);
			if (t == 0)
				i_host.xfer(8'($urandom), 1, 1'b0, r);
			for (int k = 0; k < nab; k++)
				send(SFF_PH_ADDR, shp[t][0]);
			for (int k = 0; k < 2 * (shp[t][1] != 0); k++)
				send(SFF_PH_DATA, shp[t][1]);
			i_host.sel(1'b0);
		end
		// read data on one, two and four lanes
		foreach (rl[i])
		begin
			dum = 1 + $urandom % 4;
			setup(0, 0, dum, rl[i], 1'b1, 1'b0, i == 1);
			b = 8'($urandom);
			offer(b);
			@(negedge mclk);
			check({10'h0, tx_ready}, 11'h0);
			i_host.sel(1'b1);
			send(SFF_PH_CMD, 1);
			check({10'h0, act}, 11'h1);
			i_host.clocks(dum);
			i_host.xfer(8'h00, rl[i], 1'b1, r);
			check({3'h0, r}, {3'h0, b});
			i_host.sel(1'b0);
			check({9'h0, act, tx_ready}, 11'h1);
		end
		// lane three as hardware reset
		@(posedge mclk);
		l3rst <= 1'b1;
		fle <= 1'b0;
		repeat (4) @(posedge mclk);
		i_host.pin3(1'b0);
		repeat (12) @(posedge mclk);
		check({10'h0, hwrst}, 11'h1);
		i_host.pin3(1'b1);
		repeat (12) @(posedge mclk);
		check({10'h0, hwrst}, 11'h0);
		for (int w = 0; w < 100 && exp_q.size() != 0; w++)
			@(posedge mclk);
		check(11'(exp_q.size()), 11'h0);
		end_of_test();
	end

	initial
	begin
		#200us;
		n_errors++;
		end_of_test();
	end
endmodule // testbench
